// [hw/dsb_cfg.svh]
// offsets, field positions, reset values and timing counts of the skip band / restart block
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH

`define DSB_ADDR_W 8
`define DSB_DATA_W 32
`define DSB_FREQ_W 16

`define DSB_OFF_CTRL 8'h00
`define DSB_OFF_WIDTH 8'h04
`define DSB_OFF_CENTRE 8'h08
`define DSB_OFF_START 8'h0C
`define DSB_OFF_FMIN 8'h10
`define DSB_OFF_FMAX 8'h14
`define DSB_OFF_ACC 8'h18
`define DSB_OFF_DEC 8'h1C
`define DSB_OFF_REF 8'h20
`define DSB_OFF_STATUS 8'h24
`define DSB_OFF_FREQ 8'h28
`define DSB_OFF_IRQ_STAT 8'h2C
`define DSB_OFF_IRQ_MASK 8'h30

`define DSB_CTRL_ERR_RESET 0

`define DSB_ST_STATE_LSB 0
`define DSB_ST_ATTEMPT_LSB 4
`define DSB_ST_DIN1 8
`define DSB_ST_TRIP 9
`define DSB_ST_IN_BAND 10

`define DSB_IRQ_TRIP 0
`define DSB_IRQ_RESTART 1
`define DSB_IRQ_LOCKED 2
`define DSB_IRQ_W 3

`define DSB_RST_WIDTH 16'h0000
`define DSB_RST_CENTRE 16'h0000
`define DSB_RST_START 3'h0
`define DSB_RST_FMIN 16'h0000
`define DSB_RST_FMAX 16'h1388
`define DSB_RST_ACC 16'h000A
`define DSB_RST_DEC 16'h000A

`define DSB_CLK_HZ 20000000
`define DSB_RESTART_WAIT_S 20
`define DSB_RAMP_TICK_US 1000
`define DSB_MAX_ATTEMPTS 5

`endif

// [hw/dsb_pkg.sv]
// types of the skip band / restart block
package dsb_pkg;

    typedef enum logic [2:0] {
        DSB_SEL_EDGE = 3'h0,
        DSB_SEL_LEVEL = 3'h1,
        DSB_SEL_AUTO1 = 3'h2,
        DSB_SEL_AUTO2 = 3'h3,
        DSB_SEL_AUTO3 = 3'h4,
        DSB_SEL_AUTO4 = 3'h5,
        DSB_SEL_AUTO5 = 3'h6
    } dsb_start_sel_e;

    typedef enum logic [1:0] {
        DSB_ST_IDLE = 2'b00,
        DSB_ST_RUN = 2'b01,
        DSB_ST_WAIT = 2'b10,
        DSB_ST_LOCKED = 2'b11
    } dsb_state_e;

    typedef logic [15:0] dsb_freq_t;

endpackage : dsb_pkg

// [hw/dsb_ramp_if.sv]
// carrier between the start control and the frequency ramp
`timescale 1ns/1ps
`default_nettype none
interface dsb_ramp_if;
    logic run;
    logic tick;
    dsb_pkg::dsb_freq_t ref_freq;
    dsb_pkg::dsb_freq_t fmin;
    dsb_pkg::dsb_freq_t fmax;
    dsb_pkg::dsb_freq_t centre;
    dsb_pkg::dsb_freq_t width;
    dsb_pkg::dsb_freq_t acc_step;
    dsb_pkg::dsb_freq_t dec_step;
    dsb_pkg::dsb_freq_t freq;
    logic in_band;

    modport ctl (
        output run, tick, ref_freq, fmin, fmax, centre, width, acc_step, dec_step,
        input freq, in_band
    );
    modport ramp (
        input run, tick, ref_freq, fmin, fmax, centre, width, acc_step, dec_step,
        output freq, in_band
    );
endinterface : dsb_ramp_if
`default_nettype wire

// [hw/dsb_ramp.sv]
// output frequency ramp with one skip band
`timescale 1ns/1ps
`default_nettype none
module dsb_ramp (
    input wire logic sys_clk,
    input wire logic nrst,
    dsb_ramp_if.ramp rif
);
    dsb_pkg::dsb_freq_t half_w;
    dsb_pkg::dsb_freq_t band_lo;
    logic [16:0] hi_sum;
    dsb_pkg::dsb_freq_t band_hi;
    dsb_pkg::dsb_freq_t ref_c;
    dsb_pkg::dsb_freq_t target;
    dsb_pkg::dsb_freq_t freq_r;
    dsb_pkg::dsb_freq_t freq_nxt;
    dsb_pkg::dsb_freq_t up_gap;
    dsb_pkg::dsb_freq_t dn_gap;
    logic ref_in_band;
    logic side_hi_r;

    assign half_w = rif.width >> 1;
    assign band_lo = (rif.centre > half_w) ? rif.centre - half_w : 16'h0000;
    assign hi_sum = {1'b0, rif.centre} + {1'b0, half_w};
    assign band_hi = hi_sum[16] ? 16'hFFFF : hi_sum[15:0];
    assign ref_c = (rif.ref_freq < rif.fmin) ? rif.fmin :
                   (rif.ref_freq > rif.fmax) ? rif.fmax : rif.ref_freq;
    // empty band when width is zero
    assign ref_in_band = (ref_c > band_lo) && (ref_c < band_hi);
    // park on the edge of the approach side until the reference leaves the band
    assign target = ref_in_band ? (side_hi_r ? band_hi : band_lo) : ref_c;
    assign up_gap = target - freq_r;
    assign dn_gap = freq_r - target;

    // every change of output while running, band crossing included, moves at the ramp rates; a stop drops it to zero at once
    always_comb
    begin
        freq_nxt = freq_r;
        if (!rif.run)
            freq_nxt = 16'h0000;
        else if (rif.tick && (freq_r < target))
            freq_nxt = (up_gap > rif.acc_step) ? freq_r + rif.acc_step : target;
        else if (rif.tick && (freq_r > target))
            freq_nxt = (dn_gap > rif.dec_step) ? freq_r - rif.dec_step : target;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            freq_r <= 16'h0000;
            side_hi_r <= 1'b0;
        end
        else
        begin
            freq_r <= freq_nxt;
            if (freq_r >= band_hi)
                side_hi_r <= 1'b1;
            else if (freq_r <= band_lo)
                side_hi_r <= 1'b0;
        end
    end

    assign rif.freq = freq_r;
    assign rif.in_band = ref_in_band;
endmodule : dsb_ramp
`default_nettype wire

// [hw/dsb_top.sv]
// skip band frequency control and start / automatic restart logic with Avalon-MM registers
// Notes on behaviour
// - band centre settable between minimum and maximum frequency
// - cross band at ramp rate, never dwell inside
// - reference inside band holds output at band edge
// - start select: edge, level, or auto restart
// - edge mode needs fresh closing edge after reset
// - level mode starts whenever input one closed
// - restart after trip, twenty seconds apart, max five
// - auto settings give limits one to five
// - attempt counter cleared only by power down
// - failed final attempt latches fault until error reset
// - ramp rates apply to every reference change
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dsb_cfg.svh"
module dsb_top #(
    parameter longint unsigned CLK_HZ = `DSB_CLK_HZ,
    parameter longint unsigned RESTART_WAIT_S = `DSB_RESTART_WAIT_S,
    parameter int unsigned RESTART_CYCLES = 32'(CLK_HZ * RESTART_WAIT_S),
    parameter int unsigned RAMP_TICK_CYCLES = 32'((CLK_HZ / 64'd1000000) * `DSB_RAMP_TICK_US)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [`DSB_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`DSB_DATA_W-1:0] avs_writedata,
    output logic [`DSB_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic enable_in1,
    input wire logic trip_in,
    output logic [`DSB_FREQ_W-1:0] out_freq,
    output logic running,
    output logic fault_latched,
    output logic irq
);
    dsb_ramp_if rif ();

    // register file
    dsb_pkg::dsb_freq_t width_r;
    dsb_pkg::dsb_freq_t centre_r;
    dsb_pkg::dsb_start_sel_e start_sel_r;
    dsb_pkg::dsb_freq_t fmin_r;
    dsb_pkg::dsb_freq_t fmax_r;
    dsb_pkg::dsb_freq_t acc_r;
    dsb_pkg::dsb_freq_t dec_r;
    dsb_pkg::dsb_freq_t ref_r;
    logic [`DSB_IRQ_W-1:0] irq_stat_r;
    logic [`DSB_IRQ_W-1:0] irq_mask_r;
    logic [`DSB_DATA_W-1:0] rdata_r;
    logic ack_r;

    // bus decode
    logic bus_req;
    logic wr_go;
    logic rd_go;
    logic [`DSB_DATA_W-1:0] rdata_nxt;
    dsb_pkg::dsb_freq_t wdata16;

    function automatic logic hit(input logic [`DSB_ADDR_W-1:0] a, input logic [`DSB_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ack_r;
    assign wdata16 = avs_writedata[15:0];

    // pin synchronisers: 3 stages, change accepted once stages 2 and 3 agree
    logic [2:0] din_sync_r;
    logic [2:0] trip_sync_r;
    // stages fed from the pin since reset; arming waits for them
    logic [4:0] settle_r;
    logic din_settled;
    logic din_r;
    logic din_prev_r;
    logic trip_r;
    logic trip_prev_r;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            din_sync_r <= 3'h0;
            settle_r <= 5'h00;
            trip_sync_r <= 3'h0;
            din_r <= 1'b0;
            trip_r <= 1'b0;
            din_prev_r <= 1'b0;
            trip_prev_r <= 1'b0;
        end
        else
        begin
            din_sync_r <= {din_sync_r[1:0], enable_in1};
            settle_r <= {settle_r[3:0], 1'b1};
            trip_sync_r <= {trip_sync_r[1:0], trip_in};
            if (din_sync_r[1] == din_sync_r[2])
                din_r <= din_sync_r[2];
            if (trip_sync_r[1] == trip_sync_r[2])
                trip_r <= trip_sync_r[2];
            din_prev_r <= din_r;
            trip_prev_r <= trip_r;
        end
    end

    logic trip_rise;
    assign trip_rise = trip_r & ~trip_prev_r;
    assign din_settled = settle_r[4];

    // ramp tick divider
    logic [31:0] tick_cnt_r;
    logic ramp_tick;
    assign ramp_tick = (tick_cnt_r == 32'(RAMP_TICK_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            tick_cnt_r <= 32'h0;
        else
            tick_cnt_r <= ramp_tick ? 32'h0 : tick_cnt_r + 32'h1;
    end

    // start / restart control
    dsb_pkg::dsb_state_e state_r;
    dsb_pkg::dsb_state_e state_nxt;
    logic [2:0] attempt_r;
    logic [31:0] wait_cnt_r;
    logic armed_r;
    logic err_reset;
    logic auto_mode;
    logic [2:0] attempt_limit;
    logic wait_done;
    logic start_req;
    logic ev_restart;
    logic ev_locked;

    assign err_reset = wr_go & hit(avs_address, `DSB_OFF_CTRL) & avs_writedata[`DSB_CTRL_ERR_RESET];
    assign auto_mode = (start_sel_r >= dsb_pkg::DSB_SEL_AUTO1) && (start_sel_r <= dsb_pkg::DSB_SEL_AUTO5);
    // setting values AUTO1..AUTO5 give limits 1..5
    assign attempt_limit = 3'(start_sel_r - dsb_pkg::DSB_SEL_AUTO1 + 3'h1);
    assign wait_done = (wait_cnt_r == 32'(RESTART_CYCLES - 1));
    // level mode needs no edge; other modes need a closing edge since arming
    assign start_req = (start_sel_r == dsb_pkg::DSB_SEL_LEVEL) ? din_r : (din_r & armed_r);

    always_comb
    begin
        state_nxt = state_r;
        ev_restart = 1'b0;
        ev_locked = 1'b0;
        case (state_r)
            dsb_pkg::DSB_ST_IDLE:
            begin
                if (start_req && !trip_r)
                    state_nxt = dsb_pkg::DSB_ST_RUN;
            end
            dsb_pkg::DSB_ST_RUN:
            begin
                if (trip_rise)
                begin
                    if (auto_mode && (attempt_r < attempt_limit))
                        state_nxt = dsb_pkg::DSB_ST_WAIT;
                    else
                    begin
                        state_nxt = dsb_pkg::DSB_ST_LOCKED;
                        ev_locked = 1'b1;
                    end
                end
                else if (!din_r)
                    state_nxt = dsb_pkg::DSB_ST_IDLE;
            end
            dsb_pkg::DSB_ST_WAIT:
            begin
                if (wait_done)
                begin
                    state_nxt = dsb_pkg::DSB_ST_RUN;
                    ev_restart = 1'b1;
                end
            end
            dsb_pkg::DSB_ST_LOCKED:
            begin
                if (err_reset)
                    state_nxt = dsb_pkg::DSB_ST_IDLE;
            end
            default:
                state_nxt = dsb_pkg::DSB_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= dsb_pkg::DSB_ST_IDLE;
            attempt_r <= 3'h0;
            wait_cnt_r <= 32'h0;
            armed_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (ev_restart && (attempt_r < 3'(`DSB_MAX_ATTEMPTS)))
                attempt_r <= attempt_r + 3'h1;
            if (state_r == dsb_pkg::DSB_ST_WAIT && !wait_done)
                wait_cnt_r <= wait_cnt_r + 32'h1;
            else
                wait_cnt_r <= 32'h0;
            // an open input arms; reset, error reset and a start disarm
            if (err_reset || state_nxt == dsb_pkg::DSB_ST_RUN)
                armed_r <= 1'b0;
            else if (!din_r && !din_prev_r && din_settled)
                armed_r <= 1'b1;
        end
    end

    // ramp interface
    assign rif.run = (state_r == dsb_pkg::DSB_ST_RUN);
    assign rif.tick = ramp_tick;
    assign rif.ref_freq = ref_r;
    assign rif.fmin = fmin_r;
    assign rif.fmax = fmax_r;
    assign rif.centre = centre_r;
    assign rif.width = width_r;
    assign rif.acc_step = acc_r;
    assign rif.dec_step = dec_r;

    dsb_ramp u_ramp (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .rif(rif.ramp)
    );

    // register writes with range clamping
    dsb_pkg::dsb_freq_t centre_wr;
    dsb_pkg::dsb_freq_t width_wr;
    assign centre_wr = (wdata16 < fmin_r) ? fmin_r : (wdata16 > fmax_r) ? fmax_r : wdata16;
    assign width_wr = (wdata16 > fmax_r) ? fmax_r : wdata16;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            width_r <= `DSB_RST_WIDTH;
            centre_r <= `DSB_RST_CENTRE;
            start_sel_r <= dsb_pkg::dsb_start_sel_e'(`DSB_RST_START);
            fmin_r <= `DSB_RST_FMIN;
            fmax_r <= `DSB_RST_FMAX;
            acc_r <= `DSB_RST_ACC;
            dec_r <= `DSB_RST_DEC;
            ref_r <= 16'h0000;
            irq_mask_r <= '0;
        end
        else if (wr_go)
        begin
            if (hit(avs_address, `DSB_OFF_WIDTH))
                width_r <= width_wr;
            if (hit(avs_address, `DSB_OFF_CENTRE))
                centre_r <= centre_wr;
            if (hit(avs_address, `DSB_OFF_START) && avs_writedata[2:0] <= 3'h6)
                start_sel_r <= dsb_pkg::dsb_start_sel_e'(avs_writedata[2:0]);
            if (hit(avs_address, `DSB_OFF_FMIN))
                fmin_r <= wdata16;
            if (hit(avs_address, `DSB_OFF_FMAX))
                fmax_r <= wdata16;
            if (hit(avs_address, `DSB_OFF_ACC))
                acc_r <= wdata16;
            if (hit(avs_address, `DSB_OFF_DEC))
                dec_r <= wdata16;
            if (hit(avs_address, `DSB_OFF_REF))
                ref_r <= wdata16;
            if (hit(avs_address, `DSB_OFF_IRQ_MASK))
                irq_mask_r <= avs_writedata[`DSB_IRQ_W-1:0];
        end
    end

    // sticky events, cleared by a status read; a new event wins over the clear
    logic [`DSB_IRQ_W-1:0] irq_set;
    logic irq_rd_clr;
    logic [`DSB_IRQ_W-1:0] irq_clr;
    assign irq_set = {ev_locked, ev_restart, trip_rise};
    assign irq_rd_clr = rd_go & hit(avs_address, `DSB_OFF_IRQ_STAT);
    // clear only the bits the read returned, so an event at the latch edge survives
    assign irq_clr = irq_rd_clr ? rdata_r[`DSB_IRQ_W-1:0] : {`DSB_IRQ_W{1'b0}};

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // read mux, registered one cycle before the answer
    logic [`DSB_DATA_W-1:0] status_word;
    assign status_word = {21'h0, rif.in_band, trip_r, din_r, 1'b0, attempt_r, 2'h0, state_r};

    always_comb
    begin
        case (avs_address)
            `DSB_OFF_WIDTH: rdata_nxt = {16'h0, width_r};
            `DSB_OFF_CENTRE: rdata_nxt = {16'h0, centre_r};
            `DSB_OFF_START: rdata_nxt = {29'h0, start_sel_r};
            `DSB_OFF_FMIN: rdata_nxt = {16'h0, fmin_r};
            `DSB_OFF_FMAX: rdata_nxt = {16'h0, fmax_r};
            `DSB_OFF_ACC: rdata_nxt = {16'h0, acc_r};
            `DSB_OFF_DEC: rdata_nxt = {16'h0, dec_r};
            `DSB_OFF_REF: rdata_nxt = {16'h0, ref_r};
            `DSB_OFF_STATUS: rdata_nxt = status_word;
            `DSB_OFF_FREQ: rdata_nxt = {16'h0, rif.freq};
            `DSB_OFF_IRQ_STAT: rdata_nxt = {29'h0, irq_stat_r};
            `DSB_OFF_IRQ_MASK: rdata_nxt = {29'h0, irq_mask_r};
            default: rdata_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
        end
        else
        begin
            ack_r <= bus_req & ~ack_r;
            if (avs_read && !ack_r)
                rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign out_freq = rif.freq;
    assign running = rif.run;
    assign fault_latched = (state_r == dsb_pkg::DSB_ST_LOCKED);
endmodule : dsb_top
`default_nettype wire

// [test/dsb_checker.sv]
// port assertions of the skip band / restart block
`timescale 1ns/1ps
`default_nettype none
`include "dsb_cfg.svh"
module dsb_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [`DSB_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`DSB_DATA_W-1:0] avs_writedata,
    input wire logic [`DSB_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic enable_in1,
    input wire logic trip_in,
    input wire logic [`DSB_FREQ_W-1:0] out_freq,
    input wire logic running,
    input wire logic fault_latched,
    input wire logic irq
);
    logic [3:0] open_cnt_r;
    logic [3:0] open_cnt_nxt;
    logic bus_req;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    assign bus_req = avs_read | avs_write;
    // cycles the start input has been open, saturating
    assign open_cnt_nxt = enable_in1 ? 4'h0 : (open_cnt_r == 4'hF ? 4'hF : open_cnt_r + 4'h1);

    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst)
            open_cnt_r <= 4'h0;
        else
            open_cnt_r <= open_cnt_nxt;

    AST_WAIT_ONE: assert property (bus_req && !$past(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    AST_UNMAPPED_RD: assert property (avs_read && !avs_waitrequest && avs_address > 8'h30
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(bus_req))
        else $error("interrupt dropped without bus access");
    AST_RUN_LOCK: assert property (!(running && fault_latched))
        else $error("running while fault latched");
    AST_LOCK_EXIT: assert property ($fell(fault_latched) |-> $past(avs_write))
        else $error("fault left without error reset");
    AST_START_INPUT: assert property ($rose(running) |-> $past(enable_in1, 2))
        else $error("start without closed input");
    AST_STOP_OPEN: assert property (open_cnt_r == 4'hA |-> !running)
        else $error("still running with input open");
    AST_FREQ_IDLE: assert property (!running && !$past(running) |-> out_freq == 16'h0000)
        else $error("frequency not zero while stopped");
    AST_FREQ_STEP: assert property (running && $past(running) |->
        (out_freq <= $past(out_freq) + 16'h000A) && (out_freq + 16'h000A >= $past(out_freq)))
        else $error("frequency jumped more than one step");
    AST_TICK_GAP: assert property ($changed(out_freq) && running && $past(running)
        |=> ($stable(out_freq) || !running) [*3])
        else $error("frequency steps closer than a ramp tick");

    COV_START: cover property ($rose(running));
    COV_LOCK: cover property ($rose(fault_latched));
    COV_IRQ_CLR: cover property ($fell(irq));
endmodule : dsb_checker

bind dsb_top dsb_checker
    i_dsb_checker (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .enable_in1(enable_in1),
    .trip_in(trip_in), .out_freq(out_freq), .running(running),
    .fault_latched(fault_latched), .irq(irq));
`default_nettype wire

// [test/dsb_operator.sv]
// operator start switch and trip detector at the block's pins
`timescale 1ns/1ps
`default_nettype none
module dsb_operator (
    output logic enable_in1,
    output logic trip_in,
    input wire logic sys_clk
);
    initial
    begin
        enable_in1 <= 1'b1;
        trip_in <= 1'b0;
    end

    task set_en(input logic v);
        @(posedge sys_clk);
        enable_in1 <= v;
    endtask : set_en

    // held long enough to pass the input filter
    task trip();
        @(posedge sys_clk);
        trip_in <= 1'b1;
        repeat (6) @(posedge sys_clk);
        trip_in <= 1'b0;
    endtask : trip
endmodule : dsb_operator
`default_nettype wire

// [test/dsb_top_tb.sv]
// self-checking bench of the skip band / restart block
`timescale 1ns/1ps
`default_nettype none
`include "dsb_cfg.svh"
module dsb_top_tb;
    logic sys_clk;
    logic nrst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic enable_in1;
    logic trip_in;
    logic [15:0] out_freq;
    logic running;
    logic fault_latched;
    logic irq;
    logic [31:0] rd;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int i;
    int k;
    localparam logic [7:0] OFFS [10] = '{`DSB_OFF_WIDTH, `DSB_OFF_CENTRE, `DSB_OFF_START,
        `DSB_OFF_FMIN, `DSB_OFF_FMAX, `DSB_OFF_ACC, `DSB_OFF_DEC, `DSB_OFF_IRQ_MASK,
        `DSB_OFF_CTRL, 8'h40};
    localparam logic [31:0] EXPS [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1388, 32'hA, 32'hA,
        32'h0, 32'h0, 32'h0};

    dsb_top #(.RESTART_CYCLES(50), .RAMP_TICK_CYCLES(4)) i_dsb_top (.sys_clk(sys_clk),
        .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .enable_in1(enable_in1), .trip_in(trip_in),
        .out_freq(out_freq), .running(running), .fault_latched(fault_latched), .irq(irq));
    dsb_operator i_dsb_operator (.enable_in1(enable_in1), .trip_in(trip_in), .sys_clk(sys_clk));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task final_report();
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            final_report();
        end
    end

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_pin(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: pin %b expected %b", $time, got, exp);
        end
    endtask : chk_pin

    // one Avalon access, held until waitrequest is sampled low
    task bus(input logic wr_n_rd, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr_n_rd;
        avs_read <= !wr_n_rd;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge sys_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk_word(rd, exp);
    endtask : rdc

    task wait_freq(input logic [15:0] f);
        repeat (400)
            if (out_freq !== f)
                @(posedge sys_clk);
        chk_word(32'(out_freq), 32'(f));
    endtask : wait_freq

    task wait_run(input logic v);
        repeat (80)
            if (running !== v)
                @(posedge sys_clk);
        chk_pin(running, v);
    endtask : wait_run

    task re_arm();
        i_dsb_operator.set_en(1'b0);
        repeat (8) @(posedge sys_clk);
        i_dsb_operator.set_en(1'b1);
    endtask : re_arm

    initial
    begin
        nrst = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        chk_pin(running, 1'b0);
        for (i = 0; i < 10; i++)
            rdc(OFFS[i], EXPS[i]);
        wr(`DSB_OFF_START, 32'h7);
        rdc(`DSB_OFF_START, 32'h0);
        wr(`DSB_OFF_FMIN, 32'h64);
        wr(`DSB_OFF_CENTRE, 32'h10);
        rdc(`DSB_OFF_CENTRE, 32'h64);
        wr(`DSB_OFF_CENTRE, 32'h2000);
        rdc(`DSB_OFF_CENTRE, 32'h1388);
        wr(`DSB_OFF_WIDTH, 32'h3000);
        rdc(`DSB_OFF_WIDTH, 32'h1388);
        wr(`DSB_OFF_FMIN, 32'h0);
        wr(`DSB_OFF_CENTRE, 32'h64);
        wr(`DSB_OFF_WIDTH, 32'h28);
        wr(`DSB_OFF_REF, 32'h96);
        re_arm();
        wait_run(1'b1);
        wait_freq(16'h96);
        wr(`DSB_OFF_REF, 32'h6E);
        wait_freq(16'h78);
        rdc(`DSB_OFF_STATUS, 32'h501);
        wr(`DSB_OFF_REF, 32'h5A);
        repeat (40) @(posedge sys_clk);
        chk_word(32'(out_freq), 32'h78);
        wr(`DSB_OFF_REF, 32'h32);
        wait_freq(16'h32);
        wr(`DSB_OFF_REF, 32'h5A);
        wait_freq(16'h50);
        i_dsb_operator.set_en(1'b0);
        repeat (12) @(posedge sys_clk);
        chk_pin(running, 1'b0);
        chk_word(32'(out_freq), 32'h0);
        i_dsb_operator.set_en(1'b1);
        for (k = 1; k <= 5; k++)
        begin
            nrst <= 1'b0;
            repeat (3) @(posedge sys_clk);
            nrst <= 1'b1;
            repeat (8) @(posedge sys_clk);
            rdc(`DSB_OFF_STATUS, 32'h100);
            wr(`DSB_OFF_START, 32'(k + 1));
            re_arm();
            wait_run(1'b1);
            for (i = 0; i <= k; i++)
            begin
                i_dsb_operator.trip();
                repeat (44) @(posedge sys_clk);
                chk_pin(running, 1'b0);
                if (i < k)
                    wait_run(1'b1);
                else
                    chk_pin(fault_latched, 1'b1);
            end
            rdc(`DSB_OFF_STATUS, 32'h103 | (32'(k) << 4));
        end
        wr(`DSB_OFF_CTRL, 32'h1);
        repeat (20) @(posedge sys_clk);
        chk_pin(fault_latched, 1'b0);
        chk_pin(running, 1'b0);
        rdc(`DSB_OFF_STATUS, 32'h150);
        re_arm();
        wait_run(1'b1);
        i_dsb_operator.trip();
        repeat (10) @(posedge sys_clk);
        chk_pin(fault_latched, 1'b1);
        wr(`DSB_OFF_START, 32'h1);
        wr(`DSB_OFF_CTRL, 32'h1);
        wait_run(1'b1);
        chk_pin(irq, 1'b0);
        wr(`DSB_OFF_IRQ_MASK, 32'h4);
        chk_pin(irq, 1'b1);
        rdc(`DSB_OFF_IRQ_STAT, 32'h7);
        chk_pin(irq, 1'b0);
        rdc(`DSB_OFF_IRQ_STAT, 32'h0);
        final_report();
    end
endmodule : dsb_top_tb
`default_nettype wire
